/* verilog/sbar_params.svh */
// Constants of the bus arbiter, reset and control link
`ifndef SBAR_PARAMS_SVH
`define SBAR_PARAMS_SVH
// Clock and timing
`define SBAR_CLK_NS 50
`define SBAR_RESET_NS 1600
`define SBAR_RESET_CYC ((`SBAR_RESET_NS + `SBAR_CLK_NS - 1) / `SBAR_CLK_NS)
`define SBAR_REFRESH_NS 15000
`define SBAR_REFRESH_PERIOD (`SBAR_REFRESH_NS / `SBAR_CLK_NS)
`define SBAR_REFRESH_CYC 4
`define SBAR_DMA_BLOCK 4
// Channels: 4 is never acked, 5 to 7 are 16-bit
`define SBAR_DREQ_MASK 8'hEF
`define SBAR_WIDE_BIT 2
// Link frame: start bit 1, code bits LSB first, one stop bit 0
`define SBAR_CODE_W 3
// Codes toward the companion
`define SBAR_C_REFREQ 3'h1
`define SBAR_C_REFDONE 3'h2
`define SBAR_C_DMASTB 3'h3
// Codes from the companion
`define SBAR_C_INTACK 3'h1
`define SBAR_C_CPURST 3'h2
`define SBAR_C_REFACK 3'h3
`define SBAR_C_A20LO 3'h4
`define SBAR_C_A20HI 3'h5
`define SBAR_C_KEYBOARD_RESET_N 3'h6
// Reset values
`define SBAR_RST_LINK 1'h0
`define SBAR_RST_GNT_N 1'h1
`endif

/* verilog/sbar_pkg.sv */
// Types shared by both ends of the arbiter link
`include "sbar_params.svh"
package sbar_pkg;
	typedef logic [`SBAR_CODE_W-1:0] sbar_code_t;
	typedef enum logic [2:0] {ARB_IDLE, ARB_HOLD, ARB_LOCAL, ARB_DMA, ARB_ISA, ARB_REFRESH,
		ARB_RELEASE} sbar_arb_e;
	typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} sbar_tx_e;
	typedef struct packed {
		logic [7:0] dreq_m;
		logic [7:0] dreq_s;
		logic isa_m;
		logic isa_s;
		logic local_master_request_n_m;
		logic local_master_request_n_s;
		logic pwr_m;
		logic pwr_s;
		logic link_m;
		logic link_s;
		sbar_arb_e arb;
		logic hold_req;
		logic local_master_grant_n_n;
		logic dma_owner_grant_n_n;
		logic [7:0] dack_n;
		logic [2:0] chan;
		logic wide;
		logic aen;
		logic ref_drive;
		logic tc;
		logic [2:0] xfer_cnt;
		logic [2:0] div_cnt;
		logic dma_clk;
		logic [8:0] ref_timer;
		logic ref_pend;
		logic ref_acked;
		logic ref_run;
		logic [1:0] ref_cnt;
		logic cpu_rst;
		logic sys_rst;
		logic [5:0] rst_cnt;
		logic a20;
		logic int_ack;
		sbar_tx_e tx_state;
		sbar_code_t tx_code;
		logic [1:0] tx_cnt;
		logic [2:0] tx_pend;
		logic link_out;
		logic rx_busy;
		logic [1:0] rx_cnt;
		sbar_code_t rx_shift;
	} sbar_dev_s;
	typedef struct packed {
		logic [2:0] kb_m;
		logic [2:0] a20_m;
		logic link_m;
		logic link_s;
		logic dma_owner_grant_n_m;
		logic steer;
		logic ref_seen;
		logic done_seen;
		logic stb_seen;
		sbar_tx_e tx_state;
		sbar_code_t tx_code;
		logic [1:0] tx_cnt;
		logic [4:0] tx_pend;
		logic link_ret;
		logic rx_busy;
		logic [1:0] rx_cnt;
		sbar_code_t rx_shift;
	} sbar_comp_s;
endpackage

/* verilog/sbar_link_if.sv */
// Serial control link and grant wire between the two ends
`timescale 1ns/10ps
interface sbar_link_if;
	logic link_out;
	logic link_ret;
	logic dma_owner_grant_n;
	modport dev (output link_out, output dma_owner_grant_n, input link_ret);
	modport comp (input link_out, input dma_owner_grant_n, output link_ret);
endinterface

/* verilog/sbar_device.sv */
// Bus arbiter, reset generator and link end of the arbitration chip
`timescale 1ns/10ps
`include "sbar_params.svh"
// Overview of operation
// - Hold request driven synchronously to mclk
// - Processor returns hold ack on mclk
// - Low local grant hands bus to master
// - External logic splits grant among local masters
// - Low DMA grant while DMA/ISA master owns
// - ISA master wins via DMA handshake first
// - AEN low whenever ISA master is low
// - AEN high only for DMA and refresh
// - Drive refresh low on own refresh cycles
// - ISA master drives refresh during its ownership
// - TC high only in last DMA cycle
// - DMA clock divides mclk by selected ratio
// - Processor reset synchronised to mclk
// - System reset only after power-good was low
// - Send refresh and strobe messages over link
// - Companion sends ack, reset, refresh ack, gate
// - Companion forwards every gate-A20 change
// - Keyboard reset code triggers processor restart
// - Channels 0-3 8-bit, 5-7 16-bit
module sbar_device
	import sbar_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [1:0] dma_clk_div_sel,
	output logic cpu_bus_hold_req,
	input wire logic cpu_bus_hold_ack,
	input wire logic local_master_request_n,
	output logic local_master_grant_n,
	input wire logic [7:0] dma_request,
	output logic [7:0] dma_ack_n,
	output logic dma_wide,
	input wire logic isa_master_n,
	output logic addr_enable,
	output logic terminal_count,
	input wire logic refresh_n_i,
	output logic refresh_n_o,
	output logic refresh_n_oe,
	output logic dma_clk,
	input wire logic power_ok_in,
	output logic processor_reset_out,
	output logic system_reset_out,
	output logic addr_line20_gate,
	output logic int_ack_cycle,
	sbar_link_if.dev link
);
	sbar_dev_s s;
	sbar_dev_s n;
	logic tick;
	logic done;
	logic ready;
	logic restart;
	logic [7:0] dreq_v;
	sbar_code_t code;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		tick = 1'b0;
		done = 1'b0;
		restart = 1'b0;
		code = s.rx_shift;
		// Two-flop synchronisers for pins
		n.dreq_m = dma_request;
		n.dreq_s = s.dreq_m;
		n.isa_m = isa_master_n;
		n.isa_s = s.isa_m;
		n.local_master_request_n_m = local_master_request_n;
		n.local_master_request_n_s = s.local_master_request_n_m;
		n.pwr_m = power_ok_in;
		n.pwr_s = s.pwr_m;
		n.link_m = link.link_ret;
		n.link_s = s.link_m;
		n.int_ack = 1'b0;
		dreq_v = s.dreq_s & `SBAR_DREQ_MASK;
		ready = s.ref_pend & s.ref_acked;
		if (s.div_cnt == {1'b0, dma_clk_div_sel}) begin
			n.div_cnt = 3'h0;
			n.dma_clk = ~s.dma_clk;
			tick = ~s.dma_clk;
		end else begin
			n.div_cnt = s.div_cnt + 3'h1;
		end
		// Link receiver
		if (!s.rx_busy) begin
			n.rx_busy = s.link_s;
			n.rx_cnt = 2'h0;
		end else begin
			code[s.rx_cnt] = s.link_s;
			n.rx_shift = code;
			n.rx_cnt = s.rx_cnt + 2'h1;
			if (s.rx_cnt == 2'(`SBAR_CODE_W - 1)) begin
				n.rx_busy = 1'b0;
				done = 1'b1;
			end
		end
		if (done) begin
			unique case (code)
				`SBAR_C_INTACK: n.int_ack = 1'b1;
				`SBAR_C_CPURST: restart = 1'b1;
				`SBAR_C_KEYBOARD_RESET_N: restart = 1'b1;
				`SBAR_C_REFACK: n.ref_acked = 1'b1;
				`SBAR_C_A20LO: n.a20 = 1'b0;
				`SBAR_C_A20HI: n.a20 = 1'b1;
				default: ;
			endcase
		end
		// Link transmitter, lowest pending index first
		unique case (s.tx_state)
			TX_IDLE: begin
				if (s.tx_pend[0]) begin
					n.tx_pend[0] = 1'b0;
					n.tx_code = `SBAR_C_REFREQ;
				end else if (s.tx_pend[1]) begin
					n.tx_pend[1] = 1'b0;
					n.tx_code = `SBAR_C_REFDONE;
				end else if (s.tx_pend[2]) begin
					n.tx_pend[2] = 1'b0;
					n.tx_code = `SBAR_C_DMASTB;
				end
				if (|s.tx_pend) begin
					n.link_out = 1'b1;
					n.tx_cnt = 2'h0;
					n.tx_state = TX_BITS;
				end
			end
			TX_BITS: begin
				n.link_out = s.tx_code[s.tx_cnt];
				n.tx_cnt = s.tx_cnt + 2'h1;
				if (s.tx_cnt == 2'(`SBAR_CODE_W - 1)) begin
					n.tx_state = TX_STOP;
				end
			end
			TX_STOP: begin
				n.link_out = 1'b0;
				n.tx_state = TX_IDLE;
			end
		endcase
		if (!s.pwr_s) begin
			n.cpu_rst = 1'b1;
			n.sys_rst = 1'b1;
			n.rst_cnt = 6'h0;
		end else if (restart) begin
			n.cpu_rst = 1'b1;
			n.rst_cnt = 6'h0;
		end else if (s.cpu_rst) begin
			n.rst_cnt = s.rst_cnt + 6'h1;
			if (s.rst_cnt == 6'(`SBAR_RESET_CYC - 1)) begin
				n.cpu_rst = 1'b0;
				n.sys_rst = 1'b0;
			end
		end
		// Bus arbitration
		unique case (s.arb)
			ARB_IDLE: begin
				// Request hold for any bus need
				if (ready || |dreq_v || !s.local_master_request_n_s) begin
					n.hold_req = 1'b1;
					n.arb = ARB_HOLD;
				end
			end
			ARB_HOLD: begin
				if (cpu_bus_hold_ack) begin
					if (ready) begin
						n.ref_pend = 1'b0;
						// A fresh ack in this cycle is kept
						n.ref_acked = done && (code == `SBAR_C_REFACK);
						n.ref_cnt = 2'h0;
						n.ref_drive = 1'b1;
						n.aen = 1'b1;
						n.arb = ARB_REFRESH;
					end else if (|dreq_v) begin
						for (int i = 7; i >= 0; i--) begin
							if (dreq_v[i]) begin
								n.chan = 3'(i);
							end
						end
						n.dma_owner_grant_n_n = 1'b0;
						n.dack_n[n.chan] = 1'b0;
						n.wide = n.chan[`SBAR_WIDE_BIT];
						n.xfer_cnt = 3'h0;
						n.aen = 1'b1;
						n.arb = ARB_DMA;
					end else if (!s.local_master_request_n_s) begin
						n.local_master_grant_n_n = 1'b0;
						n.arb = ARB_LOCAL;
					end else begin
						n.hold_req = 1'b0;
						n.arb = ARB_RELEASE;
					end
				end
			end
			ARB_LOCAL: begin
				if (s.local_master_request_n_s) begin
					n.local_master_grant_n_n = 1'b1;
					n.hold_req = 1'b0;
					n.arb = ARB_RELEASE;
				end
			end
			ARB_DMA: begin
				if (!s.dreq_s[s.chan]) begin
					n.dack_n = 8'hFF;
					n.dma_owner_grant_n_n = 1'b1;
					n.aen = 1'b0;
					n.tc = 1'b0;
					n.hold_req = 1'b0;
					n.arb = ARB_RELEASE;
				end else if (!s.isa_s) begin
					// Acked channel turned into ISA master
					n.aen = 1'b0;
					n.tc = 1'b0;
					n.arb = ARB_ISA;
				end else if (tick) begin
					if (s.tc) begin
						n.tc = 1'b0;
						n.dack_n = 8'hFF;
						n.dma_owner_grant_n_n = 1'b1;
						n.aen = 1'b0;
						n.hold_req = 1'b0;
						n.arb = ARB_RELEASE;
					end else begin
						n.tc = (s.xfer_cnt == 3'(`SBAR_DMA_BLOCK - 1));
						n.xfer_cnt = s.xfer_cnt + 3'h1;
						n.tx_pend[2] = 1'b1;
					end
				end
			end
			ARB_ISA: begin
				// Address enable low under ISA master
				n.aen = 1'b0;
				if (s.ref_run) begin
					n.ref_cnt = s.ref_cnt + 2'h1;
					if (s.ref_cnt == 2'(`SBAR_REFRESH_CYC - 1)) begin
						n.ref_run = 1'b0;
						n.tx_pend[1] = 1'b1;
					end
				end else if (ready) begin
					n.ref_pend = 1'b0;
					// A fresh ack in this cycle is kept
					n.ref_acked = done && (code == `SBAR_C_REFACK);
					n.ref_cnt = 2'h0;
					n.ref_run = 1'b1;
				end else if (s.isa_s || !s.dreq_s[s.chan]) begin
					n.dack_n = 8'hFF;
					n.dma_owner_grant_n_n = 1'b1;
					n.hold_req = 1'b0;
					n.arb = ARB_RELEASE;
				end
			end
			ARB_REFRESH: begin
				n.ref_cnt = s.ref_cnt + 2'h1;
				if (s.ref_cnt == 2'(`SBAR_REFRESH_CYC - 1)) begin
					n.ref_drive = 1'b0;
					n.aen = 1'b0;
					n.hold_req = 1'b0;
					n.tx_pend[1] = 1'b1;
					n.arb = ARB_RELEASE;
				end
			end
			ARB_RELEASE: begin
				if (!cpu_bus_hold_ack) begin
					n.arb = ARB_IDLE;
				end
			end
		endcase
		// Refresh timer; its set wins over a same-cycle clear
		if (s.ref_timer == 9'(`SBAR_REFRESH_PERIOD - 1)) begin
			n.ref_timer = 9'h0;
			n.ref_pend = 1'b1;
			n.tx_pend[0] = 1'b1;
		end else begin
			n.ref_timer = s.ref_timer + 9'h1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.dreq_m <= 8'h00;
			s.isa_m <= 1'h1;
			s.isa_s <= 1'h1;
			s.local_master_request_n_m <= 1'h1;
			s.local_master_request_n_s <= 1'h1;
			s.arb <= ARB_IDLE;
			s.local_master_grant_n_n <= `SBAR_RST_GNT_N;
			s.dma_owner_grant_n_n <= `SBAR_RST_GNT_N;
			s.dack_n <= 8'hFF;
			s.cpu_rst <= 1'h1;
			s.sys_rst <= 1'h1;
			s.a20 <= 1'h1;
			s.tx_state <= TX_IDLE;
			s.link_out <= `SBAR_RST_LINK;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flops, except refresh_n_o tied low
	assign cpu_bus_hold_req = s.hold_req;
	assign local_master_grant_n = s.local_master_grant_n_n;
	assign dma_ack_n = s.dack_n;
	assign dma_wide = s.wide;
	assign addr_enable = s.aen;
	assign terminal_count = s.tc;
	assign refresh_n_o = 1'b0;
	assign refresh_n_oe = s.ref_drive;
	assign dma_clk = s.dma_clk;
	assign processor_reset_out = s.cpu_rst;
	assign system_reset_out = s.sys_rst;
	assign addr_line20_gate = s.a20;
	assign int_ack_cycle = s.int_ack;
	assign link.link_out = s.link_out;
	assign link.dma_owner_grant_n = s.dma_owner_grant_n_n;
endmodule

/* verilog/sbar_companion.sv */
// Companion end of the control link
`timescale 1ns/10ps
`include "sbar_params.svh"
module sbar_companion
	import sbar_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic keyboard_reset_n,
	input wire logic addr_line20_gate_in,
	input wire logic int_ack_req,
	input wire logic cpu_reset_req,
	output logic dma_buffer_steer,
	output logic refresh_request_seen,
	output logic refresh_complete_seen,
	output logic dma_addr_strobe_seen,
	sbar_link_if.comp link
);
	sbar_comp_s s;
	sbar_comp_s n;
	logic done;
	sbar_code_t code;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = s;
		done = 1'b0;
		code = s.rx_shift;
		// Synchronisers plus one history flop
		n.kb_m = {s.kb_m[1:0], keyboard_reset_n};
		n.a20_m = {s.a20_m[1:0], addr_line20_gate_in};
		n.link_m = link.link_out;
		n.link_s = s.link_m;
		n.dma_owner_grant_n_m = link.dma_owner_grant_n;
		n.steer = ~s.dma_owner_grant_n_m;
		n.ref_seen = 1'b0;
		n.done_seen = 1'b0;
		n.stb_seen = 1'b0;
		// Receiver
		if (!s.rx_busy) begin
			n.rx_busy = s.link_s;
			n.rx_cnt = 2'h0;
		end else begin
			code[s.rx_cnt] = s.link_s;
			n.rx_shift = code;
			n.rx_cnt = s.rx_cnt + 2'h1;
			if (s.rx_cnt == 2'(`SBAR_CODE_W - 1)) begin
				n.rx_busy = 1'b0;
				done = 1'b1;
			end
		end
		// Transmitter, lowest pending index first
		unique case (s.tx_state)
			TX_IDLE: begin
				if (s.tx_pend[0]) begin
					n.tx_pend[0] = 1'b0;
					n.tx_code = `SBAR_C_KEYBOARD_RESET_N;
				end else if (s.tx_pend[1]) begin
					n.tx_pend[1] = 1'b0;
					n.tx_code = `SBAR_C_CPURST;
				end else if (s.tx_pend[2]) begin
					n.tx_pend[2] = 1'b0;
					n.tx_code = `SBAR_C_REFACK;
				end else if (s.tx_pend[3]) begin
					n.tx_pend[3] = 1'b0;
					n.tx_code = s.a20_m[2] ? `SBAR_C_A20HI : `SBAR_C_A20LO;
				end else if (s.tx_pend[4]) begin
					n.tx_pend[4] = 1'b0;
					n.tx_code = `SBAR_C_INTACK;
				end
				if (|s.tx_pend) begin
					n.link_ret = 1'b1;
					n.tx_cnt = 2'h0;
					n.tx_state = TX_BITS;
				end
			end
			TX_BITS: begin
				n.link_ret = s.tx_code[s.tx_cnt];
				n.tx_cnt = s.tx_cnt + 2'h1;
				if (s.tx_cnt == 2'(`SBAR_CODE_W - 1)) begin
					n.tx_state = TX_STOP;
				end
			end
			TX_STOP: begin
				n.link_ret = 1'b0;
				n.tx_state = TX_IDLE;
			end
		endcase
		if (done) begin
			unique case (code)
				`SBAR_C_REFREQ: begin
					n.ref_seen = 1'b1;
					n.tx_pend[2] = 1'b1;
				end
				`SBAR_C_REFDONE: n.done_seen = 1'b1;
				`SBAR_C_DMASTB: n.stb_seen = 1'b1;
				default: ;
			endcase
		end
		if (s.kb_m[2] && !s.kb_m[1]) begin
			n.tx_pend[0] = 1'b1;
		end
		if (cpu_reset_req) begin
			n.tx_pend[1] = 1'b1;
		end
		if (s.a20_m[2] != s.a20_m[1]) begin
			n.tx_pend[3] = 1'b1;
		end
		if (int_ack_req) begin
			n.tx_pend[4] = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.kb_m <= 3'h7;
			s.a20_m <= 3'h7;
			s.dma_owner_grant_n_m <= `SBAR_RST_GNT_N;
			s.tx_state <= TX_IDLE;
			s.link_ret <= `SBAR_RST_LINK;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flops
	assign dma_buffer_steer = s.steer;
	assign refresh_request_seen = s.ref_seen;
	assign refresh_complete_seen = s.done_seen;
	assign dma_addr_strobe_seen = s.stb_seen;
	assign link.link_ret = s.link_ret;
endmodule

/* dv/sbar_link_asserts.sv */
// Checker of arbiter outputs and control link framing
`timescale 1ns/10ps
module sbar_link_asserts (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic link_out,
	input wire logic link_ret,
	input wire logic dma_owner_grant_n,
	input wire logic cpu_bus_hold_ack,
	input wire logic local_master_grant_n,
	input wire logic isa_master_n,
	input wire logic addr_enable,
	input wire logic terminal_count,
	input wire logic refresh_n_oe,
	input wire logic [7:0] dma_ack_n,
	input wire logic processor_reset_out,
	input wire logic system_reset_out
);
	// ------------------------------
	// Helpers and assertions
	// ------------------------------
	logic [2:0] pos_o;
	logic [2:0] pos_r;
	logic [5:0] hi_cnt;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Frame position per link direction, length of processor reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pos_o <= 3'h0;
			pos_r <= 3'h0;
			hi_cnt <= 6'h00;
		end else begin
			pos_o <= (pos_o == 3'h4) ? 3'h0 : pos_o + {2'h0, (pos_o != 3'h0) | link_out};
			pos_r <= (pos_r == 3'h4) ? 3'h0 : pos_r + {2'h0, (pos_r != 3'h0) | link_ret};
			hi_cnt <= !processor_reset_out ? 6'h00 : hi_cnt + {5'h00, hi_cnt != 6'h3F};
		end
	end
	sequence s_ref_run;
		(refresh_n_oe && addr_enable) [*4] ##1 !refresh_n_oe;
	endsequence
	sequence s_sys_quiet;
		(!system_reset_out) [*8];
	endsequence
	AST_LINK_OUT_STOP: assert property (pos_o == 3'h4 |-> !link_out)
		else $error("outgoing stop bit not low");
	AST_LRET_STOP: assert property (pos_r == 3'h4 |-> !link_ret)
		else $error("return stop bit not low");
	AST_LOCAL_MASTER_GRANT_N_ACK: assert property ($fell(local_master_grant_n) |-> $past(cpu_bus_hold_ack))
		else $error("local grant without hold ack");
	AST_DMA_OWNER_GRANT_N_ACK: assert property ($fell(dma_owner_grant_n) |-> $past(cpu_bus_hold_ack))
		else $error("dma grant without hold ack");
	AST_AEN_OWNER: assert property (addr_enable |-> cpu_bus_hold_ack && local_master_grant_n)
		else $error("address enable outside dma or refresh");
	AST_AEN_MASTER: assert property ((!isa_master_n) [*4] |-> !addr_enable)
		else $error("address enable high with isa master");
	AST_REF_RUN: assert property ($rose(refresh_n_oe) |-> s_ref_run)
		else $error("refresh drive not four cycles");
	AST_REF_ISA: assert property ((!isa_master_n) [*4] |-> !refresh_n_oe)
		else $error("refresh driven under isa master");
	AST_TC_GRANT: assert property (terminal_count |-> !dma_owner_grant_n)
		else $error("terminal count outside dma grant");
	AST_DACK_GRANT: assert property (dma_ack_n != 8'hFF |-> !dma_owner_grant_n)
		else $error("dma ack without dma grant");
	AST_DACK4_OFF: assert property (dma_ack_n[4])
		else $error("channel four acknowledged");
	AST_CPURST_LEN: assert property ($fell(processor_reset_out) |-> hi_cnt >= 6'h20)
		else $error("processor reset too short");
	AST_SYS_QUIET: assert property ($rose(processor_reset_out) |-> s_sys_quiet)
		else $error("system reset on processor restart");
	AST_SYS_ALIGN: assert property ($fell(system_reset_out) |-> $fell(processor_reset_out))
		else $error("system reset timing differs");
endmodule

/* dv/sbar_tb.sv */
// Bench of device and companion joined by the control link
`timescale 1ns/10ps
module testbench;
	// ------------------------------
	// Signals, ends and stimulus
	// ------------------------------
	logic mclk, rstn, ack, local_master_request_n_n, isa_n, pwr, kb_n, a20_in, iack, crst, ref_pin;
	logic [1:0] sel;
	logic [7:0] dreq, dack_n;
	logic hreq, local_master_grant_n_n, wide, aen, tc, ref_o, ref_oe, dclk, prst, srst, a20, iack_cyc;
	logic steer, ref_seen, done_seen, stb_seen;
	int fails, checked, i, n, s0;
	int n_stb = 0;
	int n_done = 0;
	int n_req = 0;
	int chans[4] = '{0, 3, 5, 7};
	time t0;
	sbar_link_if u_sbar_link_if();
	sbar_device u_sbar_device (.mclk(mclk), .rstn(rstn), .dma_clk_div_sel(sel),
		.cpu_bus_hold_req(hreq), .cpu_bus_hold_ack(ack), .local_master_request_n(local_master_request_n_n),
		.local_master_grant_n(local_master_grant_n_n), .dma_request(dreq), .dma_ack_n(dack_n),
		.dma_wide(wide), .isa_master_n(isa_n), .addr_enable(aen), .terminal_count(tc),
		.refresh_n_i(ref_pin), .refresh_n_o(ref_o), .refresh_n_oe(ref_oe), .dma_clk(dclk),
		.power_ok_in(pwr), .processor_reset_out(prst), .system_reset_out(srst),
		.addr_line20_gate(a20), .int_ack_cycle(iack_cyc), .link(u_sbar_link_if.dev));
	sbar_companion u_sbar_companion (.mclk(mclk), .rstn(rstn), .keyboard_reset_n(kb_n),
		.addr_line20_gate_in(a20_in), .int_ack_req(iack), .cpu_reset_req(crst),
		.dma_buffer_steer(steer), .refresh_request_seen(ref_seen),
		.refresh_complete_seen(done_seen), .dma_addr_strobe_seen(stb_seen),
		.link(u_sbar_link_if.comp));
	sbar_link_asserts u_sbar_link_asserts (.mclk(mclk), .rstn(rstn),
		.link_out(u_sbar_link_if.link_out), .link_ret(u_sbar_link_if.link_ret),
		.dma_owner_grant_n(u_sbar_link_if.dma_owner_grant_n), .cpu_bus_hold_ack(ack),
		.local_master_grant_n(local_master_grant_n_n), .isa_master_n(isa_n), .addr_enable(aen),
		.terminal_count(tc), .refresh_n_oe(ref_oe), .dma_ack_n(dack_n),
		.processor_reset_out(prst), .system_reset_out(srst));
	// Refresh pin with pull-up
	assign ref_pin = ref_oe ? ref_o : 1'b1;
	// Clock
	always #25 mclk = ~mclk;
	always @(posedge mclk) ack <= hreq;
	// Count messages seen by the companion
	always @(posedge mclk) begin
		n_stb <= n_stb + int'(stb_seen);
		n_done <= n_done + int'(done_seen);
		n_req <= n_req + int'(ref_seen);
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic restart(input logic kb);
		@(posedge mclk) kb_n <= !kb;
		crst <= !kb;
		@(posedge mclk) crst <= 1'b0;
		for (i = 0; i < 60 && prst !== 1'b1; i++) @(negedge mclk);
		chk({prst, srst}, 16'h2);
		for (n = 0; n < 60 && prst !== 1'b0; n++) @(negedge mclk);
		chk(n >= 31 && n <= 33, 16'h1);
		@(posedge mclk) kb_n <= 1'b1;
	endtask
	task automatic dma_run(input int ch);
		s0 = n_stb;
		@(posedge mclk) dreq[ch] <= 1'b1;
		for (i = 0; i < 400 && dack_n[ch] !== 1'b0; i++) @(negedge mclk);
		chk({dack_n, u_sbar_link_if.dma_owner_grant_n, aen, wide},
			{~(8'h01 << ch), 2'h1, ch >= 5});
		for (i = 0; i < 100 && tc !== 1'b1; i++) @(negedge mclk);
		chk(steer, 16'h1);
		for (n = 0; n < 20 && tc === 1'b1; n++) @(negedge mclk);
		chk(n, 16'h8);
		@(posedge mclk) dreq[ch] <= 1'b0;
		for (i = 0; i < 60 && dack_n !== 8'hFF; i++) @(negedge mclk);
		repeat (20) @(negedge mclk);
		chk(n_stb - s0, 16'h4);
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		test_done();
	end
	initial begin
		{mclk, rstn, pwr, iack, crst, fails, checked} = '0;
		{local_master_request_n_n, isa_n, kb_n, a20_in} = 4'hF;
		sel = 2'h0;
		dreq = 8'h00;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (5) @(negedge mclk);
		chk({prst, srst}, 16'h3);
		@(posedge mclk) pwr <= 1'b1;
		for (n = 0; n < 100 && prst !== 1'b0; n++) @(negedge mclk);
		chk({n >= 32 && n <= 36, srst}, 16'h2);
		for (n = 0; n < 2; n++) begin
			@(posedge mclk) a20_in <= n[0];
			for (i = 0; i < 40 && a20 !== n[0]; i++) @(negedge mclk);
			chk(a20, 16'(n));
		end
		@(posedge mclk) iack <= 1'b1;
		@(posedge mclk) iack <= 1'b0;
		for (i = 0; i < 40 && iack_cyc !== 1'b1; i++) @(negedge mclk);
		chk(iack_cyc, 16'h1);
		restart(1'b1);
		restart(1'b0);
		for (n = 0; n < 4; n++) begin
			@(posedge mclk) sel <= 2'(n);
			repeat (20) @(posedge mclk);
			@(posedge dclk) t0 = $time;
			@(posedge dclk) chk(16'(($time - t0) / 50), 16'(2 * (n + 1)));
		end
		// one local master, no external split needed
		@(posedge mclk) local_master_request_n_n <= 1'b0;
		for (i = 0; i < 40 && local_master_grant_n_n !== 1'b0; i++) @(negedge mclk);
		chk({local_master_grant_n_n, ack, aen}, 16'h2);
		@(posedge mclk) local_master_request_n_n <= 1'b1;
		for (i = 0; i < 40 && local_master_grant_n_n !== 1'b1; i++) @(negedge mclk);
		chk(local_master_grant_n_n, 16'h1);
		foreach (chans[k]) dma_run(chans[k]);
		@(posedge mclk) dreq <= 8'h10;
		repeat (30) @(negedge mclk);
		chk(dack_n, 16'hFF);
		@(posedge mclk) dreq <= 8'h40;
		for (i = 0; i < 400 && dack_n[6] !== 1'b0; i++) @(negedge mclk);
		// master takes bus after its ack
		@(posedge mclk) isa_n <= 1'b0;
		repeat (6) @(negedge mclk);
		chk({aen, dack_n[6]}, 16'h0);
		// a refresh falls inside the master's ownership
		n = n_done;
		for (i = 0; i < 700 && n_done == n; i++) @(negedge mclk);
		chk(16'(n_done - n), 16'h1);
		chk({aen, ref_oe, dack_n[6]}, 16'h0);
		@(posedge mclk) isa_n <= 1'b1;
		dreq <= 8'h00;
		s0 = n_req;
		for (i = 0; i < 700 && ref_oe !== 1'b1; i++) @(negedge mclk);
		chk({aen, ref_pin}, 16'h2);
		chk(16'(n_req - s0), 16'h1);
		n = n_done;
		repeat (30) @(negedge mclk);
		chk(16'(n_done - n), 16'h1);
		test_done();
	end
endmodule
